// ---- hw/aac_config_regs.sv ----
`timescale 1ns/1ps
`include "aac_params.svh"


module aac_config_regs
  import aac_pkg::*;
#(
  parameter int TICK_CYCLES     = `AAC_TICK_US * `AAC_CLK_MHZ,
  parameter int ST_BLANK_CYCLES = `AAC_ST_BLANK_US * `AAC_CLK_MHZ
)
(
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic [2:0]      s_axi_awprot,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic [2:0]      s_axi_arprot,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [1:0]      arm_raw,
  output logic [1:0]           arm_pin_out,
  output logic [1:0]           arm_pin_oe_n,
  output logic [1:0]           selftest_active,
  output logic [1:0]           offset_cancel_hold,
  output logic [1:0]           offset_monitor_en,
  output logic [1:0][3:0]      filter_select,
  output logic [1:0]           filter_slow,
  output logic [1:0]           filter_valid,
  output logic [1:0][4:0]      arm_avg_pos,
  output logic [1:0][4:0]      arm_avg_neg,
  output logic [1:0][3:0]      arm_count_limit,
  output logic                 init_done_lock,
  output logic                 crc_enable,
  output logic [7:0]           crc_value
);

  localparam int NSEL = 6;
  localparam int SEL_DEV = 0;
  localparam int SEL_AX  = 1;
  localparam int SEL_ARM = 3;
  localparam int SEL_STA = 5;

  function automatic logic [NSEL-1:0] aac_decode(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    aac_decode = {idx == `AAC_IDX_STATUS, idx == `AAC_IDX_ARM_Y, idx == `AAC_IDX_ARM_X,
                  idx == `AAC_IDX_AXIS_Y, idx == `AAC_IDX_AXIS_X, idx == `AAC_IDX_DEVICE_CONFIG};
  endfunction : aac_decode

  function automatic logic [7:0] aac_crc8(input logic [39:0] d);
    logic [7:0] c;
    c = `AAC_CRC_SEED;
    for (int k = 39; k >= 0; k--) begin
      c = (c[7] ^ d[k]) ? ({c[6:0], 1'b0} ^ `AAC_CRC_POLY) : {c[6:0], 1'b0};
    end
    aac_crc8 = c;
  endfunction : aac_crc8

  function automatic logic [11:0] aac_stretch(input logic [1:0] code);
    logic [11:0] t;
    unique case (code)
      2'b00: t = `AAC_STRETCH_0;
      2'b01: t = `AAC_STRETCH_1;
      2'b10: t = `AAC_STRETCH_2;
      2'b11: t = `AAC_STRETCH_3;
    endcase
    aac_stretch = t;
  endfunction : aac_stretch

  logic [7:0]       device_config_reg;
  logic             lock_reg;
  logic [1:0][7:0]  axis_cfg_reg;
  logic [1:0][7:0]  arm_cfg_reg;
  logic             aw_hold_reg;
  logic [7:0]       aw_addr_reg;
  logic             w_hold_reg;
  logic [7:0]       w_data_reg;
  logic             w_strb_reg;
  logic [15:0]      tick_cnt_reg;
  logic             tick_reg;
  logic [1:0]       st_act_q_reg;
  logic [1:0][15:0] blank_cnt_reg;

  logic             wr_fire;
  logic [NSEL-1:0]  wr_sel;
  logic [NSEL-1:0]  rd_sel;
  logic             wr_open;
  logic [1:0]       st_act;
  logic             mon_req;
  aac_arm_mode_t    mode;
  logic             mode_avg;
  logic             mode_cnt;
  logic [1:0]       stretched;
  logic [31:0]      status_word;

  assign wr_fire  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_sel   = aac_decode(aw_addr_reg);
  assign rd_sel   = aac_decode(s_axi_araddr);
  assign wr_open  = wr_fire && w_strb_reg && !lock_reg;
  assign mon_req  = device_config_reg[`AAC_OFMON_BIT] || !device_config_reg[`AAC_OC_BIT];
  assign mode     = aac_arm_mode_t'(device_config_reg[`AAC_MODE_MSB:`AAC_MODE_LSB]);
  assign mode_avg = (mode == AAC_ARM_AVG_HI) || (mode == AAC_ARM_AVG_LO);
  assign mode_cnt = (mode == AAC_ARM_CNT_HI) || (mode == AAC_ARM_CNT_LO);

  // ---- write channel ----
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      aw_hold_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_reg   <= 1'b0;
    end else if (!aw_hold_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
      w_hold_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_strb_reg   <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata[7:0];
      w_strb_reg   <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_hold_reg   <= 1'b0;
    end else if (!w_hold_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // locked writes still answer okay: the host sees no fault, only unchanged contents
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AAC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (|wr_sel) ? `AAC_RESP_OKAY : `AAC_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---- registers ----
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      device_config_reg <= `AAC_DEVICE_CONFIG_RST;
    end else if (wr_open && wr_sel[SEL_DEV]) begin
      device_config_reg <= w_data_reg & `AAC_DEVICE_CONFIG_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else if (wr_open && wr_sel[SEL_DEV] && w_data_reg[`AAC_LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // ---- divider: one tick every 128 us ----
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  genvar ax;
  generate
    for (ax = 0; ax < 2; ax++) begin : g_axis
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          axis_cfg_reg[ax] <= `AAC_AXIS_RST;
        end else if (wr_open && wr_sel[SEL_AX + ax]) begin
          axis_cfg_reg[ax] <= w_data_reg & `AAC_AXIS_MASK;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          arm_cfg_reg[ax] <= `AAC_ARM_RST;
        end else if (wr_open && wr_sel[SEL_ARM + ax]) begin
          arm_cfg_reg[ax] <= w_data_reg & `AAC_ARM_MASK;
        end
      end

      // lock disables self-test while the stored bit keeps its last written value
      assign st_act[ax] = axis_cfg_reg[ax][`AAC_ST_BIT] && !lock_reg;

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          st_act_q_reg[ax]  <= 1'b0;
          blank_cnt_reg[ax] <= 16'h0000;
        end else begin
          st_act_q_reg[ax] <= st_act[ax];
          if (st_act_q_reg[ax] && !st_act[ax]) begin
            blank_cnt_reg[ax] <= 16'(ST_BLANK_CYCLES);
          end else if (blank_cnt_reg[ax] != 16'h0000) begin
            blank_cnt_reg[ax] <= blank_cnt_reg[ax] - 16'h0001;
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          selftest_active[ax]    <= 1'b0;
          offset_cancel_hold[ax] <= 1'b0;
          offset_monitor_en[ax]  <= 1'b0;
        end else begin
          selftest_active[ax]    <= st_act[ax];
          offset_cancel_hold[ax] <= st_act[ax];
          offset_monitor_en[ax]  <= mon_req && !st_act[ax] &&
                                    (blank_cnt_reg[ax] == 16'h0000) &&
                                    !(st_act_q_reg[ax] && !st_act[ax]);
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          filter_select[ax] <= 4'h0;
          filter_slow[ax]   <= 1'b0;
          filter_valid[ax]  <= 1'b1;
        end else begin
          filter_select[ax] <= axis_cfg_reg[ax][`AAC_LPF_MSB:`AAC_LPF_LSB];
          filter_slow[ax]   <= axis_cfg_reg[ax][`AAC_LPF_MSB];
          filter_valid[ax]  <= !(axis_cfg_reg[ax][`AAC_LPF_MSB-1] &&
                                 axis_cfg_reg[ax][`AAC_LPF_MSB-2]);
        end
      end

      // window and limit decodes read as zero outside the modes that use them
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          arm_avg_pos[ax]     <= 5'h00;
          arm_avg_neg[ax]     <= 5'h00;
          arm_count_limit[ax] <= 4'h0;
        end else begin
          arm_avg_pos[ax] <= mode_avg ?
            (`AAC_WIN_BASE << arm_cfg_reg[ax][`AAC_AWS_P_MSB:`AAC_AWS_P_LSB]) : 5'h00;
          arm_avg_neg[ax] <= mode_avg ?
            (`AAC_WIN_BASE << arm_cfg_reg[ax][`AAC_AWS_N_MSB:`AAC_AWS_N_LSB]) : 5'h00;
          arm_count_limit[ax] <= mode_cnt ?
            4'((`AAC_WIN_BASE << arm_cfg_reg[ax][`AAC_AWS_P_MSB:`AAC_AWS_P_LSB]) - 5'h01)
            : 4'h0;
        end
      end

      aac_arm_stretch u_stretch (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .tick          (tick_reg),
        .arm_in        (arm_raw[ax]),
        .stretch_ticks ((mode_avg || mode_cnt) ?
                        aac_stretch(arm_cfg_reg[ax][`AAC_APS_MSB:`AAC_APS_LSB]) :
                        `AAC_STRETCH_0),
        .arm_out       (stretched[ax])
      );

      // odd modes other than pcm drive active low; pcm passes the raw stream untouched
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          arm_pin_out[ax]  <= 1'b0;
          arm_pin_oe_n[ax] <= 1'b1;
        end else begin
          arm_pin_oe_n[ax] <= (mode == AAC_ARM_OFF);
          if (mode == AAC_ARM_PCM) begin
            arm_pin_out[ax] <= arm_raw[ax];
          end else begin
            arm_pin_out[ax] <= stretched[ax] ^ mode[0];
          end
        end
      end
    end
  endgenerate

  // ---- writable-register check ----
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      crc_value  <= 8'h00;
      crc_enable <= 1'b0;
    end else begin
      crc_enable <= lock_reg;
      crc_value  <= lock_reg ? aac_crc8({device_config_reg, axis_cfg_reg[0], axis_cfg_reg[1],
                                         arm_cfg_reg[0], arm_cfg_reg[1]}) : 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      init_done_lock <= 1'b0;
    end else begin
      init_done_lock <= lock_reg;
    end
  end

  // ---- read channel ----
  assign status_word = {16'h0000, crc_value, 3'b000, lock_reg,
                        (blank_cnt_reg[1] != 16'h0000), (blank_cnt_reg[0] != 16'h0000), st_act};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AAC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= (|rd_sel) ? `AAC_RESP_OKAY : `AAC_RESP_DECERR;
      unique case (1'b1)
        rd_sel[SEL_DEV]:     s_axi_rdata <= {24'h000000, device_config_reg};
        rd_sel[SEL_AX]:      s_axi_rdata <= {24'h000000, axis_cfg_reg[0]};
        rd_sel[SEL_AX + 1]:  s_axi_rdata <= {24'h000000, axis_cfg_reg[1]};
        rd_sel[SEL_ARM]:     s_axi_rdata <= {24'h000000, arm_cfg_reg[0]};
        rd_sel[SEL_ARM + 1]: s_axi_rdata <= {24'h000000, arm_cfg_reg[1]};
        rd_sel[SEL_STA]:     s_axi_rdata <= status_word;
        default:             s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : aac_config_regs

// ---- hw/aac_params.svh ----
`ifndef AAC_PARAMS_SVH
`define AAC_PARAMS_SVH

// register indices; byte address is index times four
`define AAC_IDX_DEVICE_CONFIG     6'h0b
`define AAC_IDX_AXIS_X     6'h0c
`define AAC_IDX_AXIS_Y     6'h0d
`define AAC_IDX_ARM_X      6'h0e
`define AAC_IDX_ARM_Y      6'h0f
`define AAC_IDX_STATUS     6'h20

// field positions
`define AAC_ST_BIT         7
`define AAC_LPF_MSB        3
`define AAC_LPF_LSB        0
`define AAC_APS_MSB        5
`define AAC_APS_LSB        4
`define AAC_AWS_N_MSB      3
`define AAC_AWS_N_LSB      2
`define AAC_AWS_P_MSB      1
`define AAC_AWS_P_LSB      0
`define AAC_OC_BIT         7
`define AAC_LOCK_BIT       5
`define AAC_OFMON_BIT      3
`define AAC_MODE_MSB       2
`define AAC_MODE_LSB       0

// writable masks (reserved bits read zero) and reset values
`define AAC_AXIS_MASK      8'h8f
`define AAC_ARM_MASK       8'h3f
`define AAC_DEVICE_CONFIG_MASK    8'hbf
`define AAC_AXIS_RST       8'h00
`define AAC_ARM_RST        8'h0f
`define AAC_DEVICE_CONFIG_RST     8'h00

// timing
`define AAC_CLK_MHZ        200
`define AAC_TICK_US        128
`define AAC_ST_BLANK_US    100
`define AAC_STRETCH_0      12'h000
`define AAC_STRETCH_1      12'h080
`define AAC_STRETCH_2      12'h200
`define AAC_STRETCH_3      12'h7ff

// arming window decode
`define AAC_WIN_BASE       5'h02

// writable-register check
`define AAC_CRC_POLY       8'h07
`define AAC_CRC_SEED       8'hff

// bus responses
`define AAC_RESP_OKAY      2'b00
`define AAC_RESP_DECERR    2'b11

`endif

// ---- hw/aac_pkg.sv ----
package aac_pkg;

  typedef enum logic [2:0] {
    AAC_ARM_OFF    = 3'b000,
    AAC_ARM_PCM    = 3'b001,
    AAC_ARM_AVG_HI = 3'b010,
    AAC_ARM_AVG_LO = 3'b011,
    AAC_ARM_CNT_HI = 3'b100,
    AAC_ARM_CNT_LO = 3'b101,
    AAC_ARM_RAW_HI = 3'b110,
    AAC_ARM_RAW_LO = 3'b111
  } aac_arm_mode_t;

  typedef enum logic [0:0] {
    AAC_STR_IDLE = 1'b0,
    AAC_STR_HOLD = 1'b1
  } aac_str_state_t;

endpackage : aac_pkg

// ---- hw/aac_arm_stretch.sv ----
`timescale 1ns/1ps
`include "aac_params.svh"

module aac_arm_stretch
  import aac_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        arm_in,
  input  wire logic [11:0] stretch_ticks,
  output logic             arm_out
);

  aac_str_state_t state_reg;
  logic [11:0]    count_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= AAC_STR_IDLE;
    end else begin
      unique case (state_reg)
        AAC_STR_IDLE: begin
          if (arm_in && (stretch_ticks != `AAC_STRETCH_0)) begin
            state_reg <= AAC_STR_HOLD;
          end
        end
        AAC_STR_HOLD: begin
          if (!arm_in && tick && (count_reg == `AAC_STRETCH_0)) begin
            state_reg <= AAC_STR_IDLE;
          end
        end
      endcase
    end
  end

  // hold time counts whole ticks, so the stretch lands within one tick of nominal
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_reg <= `AAC_STRETCH_0;
    end else if (arm_in) begin
      count_reg <= stretch_ticks;
    end else if (tick && (count_reg != `AAC_STRETCH_0)) begin
      count_reg <= count_reg - 12'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arm_out <= 1'b0;
    end else begin
      arm_out <= arm_in || (state_reg == AAC_STR_HOLD);
    end
  end

endmodule : aac_arm_stretch

// ---- verif/aac_config_regs_props.sv ----
`timescale 1ns/1ps

module aac_config_regs_props (
  input  wire logic            sys_clk,
  input  wire logic            rst,
  input  wire logic            s_axi_awvalid,
  input  wire logic            s_axi_awready,
  input  wire logic            s_axi_wvalid,
  input  wire logic            s_axi_wready,
  input  wire logic            s_axi_bvalid,
  input  wire logic            s_axi_arvalid,
  input  wire logic            s_axi_arready,
  input  wire logic            s_axi_rvalid,
  input  wire logic [1:0]      selftest_active,
  input  wire logic [1:0]      offset_cancel_hold,
  input  wire logic [1:0]      offset_monitor_en,
  input  wire logic [1:0][3:0] filter_select,
  input  wire logic [1:0]      filter_slow,
  input  wire logic [1:0]      filter_valid,
  input  wire logic [1:0][4:0] arm_avg_pos,
  input  wire logic [1:0][3:0] arm_count_limit,
  input  wire logic            init_done_lock,
  input  wire logic            crc_enable,
  input  wire logic [7:0]      crc_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_st_end;
    $fell(selftest_active[0]);
  endsequence

  a_lock_sticky: assert property ($past(init_done_lock) |-> init_done_lock)
    else $error("lock bit cleared without reset");
  a_st_locked: assert property (init_done_lock && $past(init_done_lock) |-> selftest_active == 2'b00)
    else $error("self-test active while locked");
  a_oc_hold: assert property (offset_cancel_hold == selftest_active)
    else $error("offset cancel hold differs from self-test");
  a_mon_in_st: assert property (!(|(selftest_active & offset_monitor_en)))
    else $error("offset monitor on during self-test");
  // the monitor must stay blanked for a while after self-test ends
  a_mon_blank: assert property (s_st_end |-> !offset_monitor_en[0] [*3])
    else $error("offset monitor not blanked after self-test");
  a_crc_gate: assert property (crc_enable == init_done_lock && (crc_enable || crc_value == 8'h00))
    else $error("check value active without lock");
  a_filter_map: assert property (filter_slow[0] == filter_select[0][3]
    && filter_valid[0] == (filter_select[0][2:1] != 2'b11))
    else $error("filter decode wrong");
  a_arm_decode: assert property ((arm_avg_pos[0] inside {5'd0, 5'd2, 5'd4, 5'd8, 5'd16})
    && (arm_count_limit[0] inside {4'd0, 4'd1, 4'd3, 4'd7, 4'd15})
    && !(arm_avg_pos[0] != 5'd0 && arm_count_limit[0] != 4'd0))
    else $error("arming window decode wrong");
  // both halves are parked for one cycle before the response is raised
  a_wr_resp: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule : aac_config_regs_props

// ---- verif/aac_host_bfm.sv ----
`timescale 1ns/1ps

module aac_host_bfm (
  input  wire logic        sys_clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} <= '0;
    {s_axi_araddr, s_axi_arvalid} <= '0;
    s_axi_wstrb <= 4'h1;
    // ready lines stay high, so every response is taken at the edge that shows it
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    logic [7:0] m;
    // reserved bits of the axis and arm registers go out as zero; device config goes out unmasked
    m = (a == 8'h38 || a == 8'h3c) ? 8'h3f : (a == 8'h30 || a == 8'h34) ? 8'h8f : 8'hff;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v & m};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    v = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask : rd
endmodule : aac_host_bfm

// ---- verif/test_aac_config_regs.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %0h got %0h", nm, e, g); end end

module test_aac_config_regs;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       s_axi_awaddr, s_axi_araddr, crc_value, d;
  logic [2:0]       s_axi_awprot = 3'h0;
  logic [2:0]       s_axi_arprot = 3'h0;
  logic [31:0]      s_axi_wdata, s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, init_done_lock, crc_enable;
  logic [1:0]       arm_raw = 2'b00;
  logic [1:0]       arm_pin_out, arm_pin_oe_n, selftest_active, offset_cancel_hold;
  logic [1:0]       offset_monitor_en, filter_slow, filter_valid;
  logic [1:0][3:0]  filter_select, arm_count_limit;
  logic [1:0][4:0]  arm_avg_pos, arm_avg_neg;
  int               n_mismatch = 0;
  int               check_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  // short tick and blank counts keep the stretch and self-test blanking tests brief
  aac_config_regs #(.TICK_CYCLES(8), .ST_BLANK_CYCLES(5)) i_dut (.*);
  aac_host_bfm i_host (.*);

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_host.wr(a, v, r);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_host.rd(a, d, r);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask : settle
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  function automatic logic [7:0] crc8(input logic [39:0] v);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 39; i >= 0; i--) c = (c[7] ^ v[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : crc8
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset

  initial begin
    do_reset();
    rd(8'h30);
    `CHK("axis_x reset", 8'h00, d)
    rd(8'h38);
    `CHK("arm_x reset", 8'h0f, d)
    rd(8'h40);
    `CHK("unmapped resp", 2'b11, r)
    tend("reset");
    wr(8'h30, 8'h85);
    settle();
    `CHK("st active", 2'b01, selftest_active)
    `CHK("filter x", 4'h5, filter_select[0])
    `CHK("oc hold", 2'b01, offset_cancel_hold)
    `CHK("mon in st", 1'b0, offset_monitor_en[0])
    rd(8'h30);
    `CHK("axis_x read", 8'h85, d)
    wr(8'h30, 8'h05);
    settle();
    `CHK("st cleared", 2'b00, selftest_active)
    `CHK("mon blanked", 1'b0, offset_monitor_en[0])
    settle();
    settle();
    `CHK("mon back", 1'b1, offset_monitor_en[0])
    tend("selftest");
    for (int c = 0; c < 16; c++) begin
      wr(8'h34, 8'(c));
      settle();
      `CHK("flt sel", 4'(c), filter_select[1])
      `CHK("flt valid", c[2:1] != 2'b11, filter_valid[1])
      `CHK("flt slow", c[3], filter_slow[1])
    end
    tend("filter");
    wr(8'h38, 8'h1b);
    for (int m = 0; m < 8; m++) begin
      wr(8'h2c, 8'(m));
      settle();
      `CHK("avg pos", (m == 2 || m == 3) ? 5'd16 : 5'd0, arm_avg_pos[0])
      `CHK("avg neg", (m == 2 || m == 3) ? 5'd8 : 5'd0, arm_avg_neg[0])
      `CHK("count", (m == 4 || m == 5) ? 4'd15 : 4'd0, arm_count_limit[0])
      `CHK("pin off", m == 0, arm_pin_oe_n[0])
      `CHK("pin idle", (m > 1) && m[0], arm_pin_out[0])
    end
    tend("mode");
    wr(8'h2c, 8'h02);
    settle();
    arm_raw <= 2'b01;
    repeat (4) @(posedge sys_clk);
    `CHK("arm on", 1'b1, arm_pin_out[0])
    arm_raw <= 2'b00;
    repeat (500) @(posedge sys_clk);
    `CHK("stretch hold", 1'b1, arm_pin_out[0])
    repeat (600) @(posedge sys_clk);
    `CHK("stretch end", 1'b0, arm_pin_out[0])
    tend("stretch");
    wr(8'h30, 8'h85);
    wr(8'h2c, 8'h22);
    settle();
    `CHK("lock set", 1'b1, init_done_lock)
    `CHK("crc on", 1'b1, crc_enable)
    `CHK("st off", 2'b00, selftest_active)
    wr(8'h30, 8'h0c);
    rd(8'h30);
    `CHK("axis_x locked", 8'h85, d)
    wr(8'h38, 8'h00);
    rd(8'h38);
    `CHK("arm_x locked", 8'h1b, d)
    wr(8'h2c, 8'h00);
    settle();
    `CHK("lock kept", 1'b1, init_done_lock)
    `CHK("crc", crc8({8'h22, 8'h85, 8'h0f, 8'h1b, 8'h0f}), crc_value)
    tend("lock");
    do_reset();
    rd(8'h30);
    `CHK("axis_x reset2", 8'h00, d)
    `CHK("lock reset", 1'b0, init_done_lock)
    `CHK("crc off", 1'b0, crc_enable)
    tend("reset2");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end
endmodule : test_aac_config_regs

bind aac_config_regs aac_config_regs_props i_props (.*);
